//--- lcdf_panel.sv
/*
 lcdf_panel: lcd panel model at the common and segment electrodes.
 assumes one-hot commons and registered segments on clk.
*/
`timescale 1ns/1ps
module lcdf_panel
  import lcdf_pkg::*;
(
  input wire logic clk,
  input wire logic [COMMONS-1:0] commonOut,
  input wire logic [SEGMENTS-1:0] segmentOut,
  output logic [3:0] pixFirst,
  output logic [3:0] pixSecond
);
  // ------
  // pixel capture per common line
  // ------
  always_ff @(posedge clk) begin
    for (int c = 0; c < 4; c++) begin
      if (commonOut[c]) begin
        pixFirst[c] <= segmentOut[0];
        pixSecond[c] <= segmentOut[1];
      end
    end
  end
endmodule : lcdf_panel

//--- lcdf_pkg.sv
/*
 lcdf_pkg: constants and types of the lcd frame interrupt and clock block.
 assumes a 32-bit classic wishbone slave, one word per register.
*/
package lcdf_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MODULE_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_INT_FLAG = 8'h08;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_DISPLAY_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_RAM_BASE = 8'h80;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int DEBUG_KEEP_BIT = 8;
  localparam int DIV_LSB = 4;
  localparam int SRC_LSB = 0;
  localparam int COMMON_ORDER_BIT = 5;
  localparam logic DEBUG_KEEP_RESET = 1'b1;
  localparam logic COMMON_ORDER_RESET = 1'b1;
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  localparam logic [3:0] DIV_BASE_LOG2 = 4'h4;
  localparam logic [1:0] SRC_LOW_SPEED = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;
  // ----------------------------------------------------------------
  // display memory: 1/4 duty, 88 segments per area
  // ----------------------------------------------------------------
  localparam int SEGMENTS = 88;
  localparam int COMMONS = 4;
  localparam logic [15:0] AREA0_FIRST = 16'h7000;
  localparam logic [15:0] AREA0_LAST = 16'h70ae;
  localparam logic [15:0] AREA1_FIRST = 16'h7100;
  localparam logic [15:0] AREA1_LAST = 16'h71ae;
  localparam logic [8:0] RAM_BYTES = 9'h0b0;
  localparam logic [3:0] FRAME_LINES = 4'h4;

  typedef struct packed {
    logic debugKeep;
    logic [2:0] divSel;
    logic [1:0] srcSel;
  } lcdf_clock_t;
endpackage : lcdf_pkg

//--- lcdf_top.sv
/*
 lcdf_top: segment lcd frame timing, frame interrupt, clock control and
 display ram (1/4 duty) behind a classic wishbone slave.
 assumes one synchronous clock; the source clocks arrive as enable pulses.
*/
// Overview of operation
// RL1: frame switch sets flag, write one clears
// RL2: one readable writable frame interrupt enable
// RL3: interrupt request only when flag and enable
// RL4: even bytes drive segments, common order selectable
// RL5: odd bytes are plain ram, not displayed
// RL6: debug keep bit eight, resets to one
// RL7: debug keep low stops clock in debug
// RL8: divider 16 to 512, low-speed sources undivided
// RL9: clock control writable only while module off
// RL10: writing zero keeps flag; set beats clear
`timescale 1ns/1ps
module lcdf_top
  import lcdf_pkg::*;
#(
  parameter int FRAME_DIV = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic debugMode,
  input wire logic [3:0] srcTick,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq,
  output logic [COMMONS-1:0] commonOut,
  output logic [SEGMENTS-1:0] segmentOut
);
  if (FRAME_DIV < 1 || FRAME_DIV > 65535) begin : gBadDiv
    $error("FRAME_DIV out of range");
  end
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic [7:0] adr;
  logic [8:0] ramIdx;
  logic ramHit;
  lcdf_clock_t clockCtl;
  logic moduleOn;
  logic frameFlag;
  logic frameEnable;
  logic commonOrder;
  logic [7:0] ram [0:2*SEGMENTS-1];
  logic [7:0] ramByte;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign adr = wb_adr_i[7:0];
  // ram window: byte n of area a in the wb_adr_i[11] region (0x800 + 4n), word per byte
  assign ramIdx = wb_adr_i[10:2];
  assign ramHit = wb_adr_i[11] && (ramIdx < 9'(2*SEGMENTS));
  assign ramByte = ram[ramIdx[7:0]];
  // ----------------------------------------------------------------
  // wishbone ack and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= req;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce && req) begin
      wb_dat_o <= 32'h0000_0000;
      if (ramHit) begin
        wb_dat_o <= {24'h00_0000, ramByte};
      end else begin
        case (adr)
          ADDR_CLOCK_CONTROL: begin
            wb_dat_o[DEBUG_KEEP_BIT] <= clockCtl.debugKeep;
            wb_dat_o[DIV_LSB +: 3] <= clockCtl.divSel;
            wb_dat_o[SRC_LSB +: 2] <= clockCtl.srcSel;
          end
          ADDR_MODULE_CONTROL: wb_dat_o[0] <= moduleOn;
          ADDR_INT_FLAG: wb_dat_o[0] <= frameFlag;
          ADDR_INT_ENABLE: wb_dat_o[0] <= frameEnable; // [RL2]
          ADDR_DISPLAY_CONTROL: begin
            wb_dat_o[COMMON_ORDER_BIT] <= commonOrder;
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clockCtl.debugKeep <= DEBUG_KEEP_RESET; // [RL6]
      clockCtl.divSel <= 3'h0;
      clockCtl.srcSel <= 2'h0;
    end else if (ce && wr && !ramHit && adr == ADDR_CLOCK_CONTROL
                 && !moduleOn) begin // [RL9]
      if (wb_sel_i[1]) begin
        clockCtl.debugKeep <= wb_dat_i[DEBUG_KEEP_BIT]; // [RL6]
      end
      clockCtl.divSel <= wb_dat_i[DIV_LSB +: 3];
      clockCtl.srcSel <= wb_dat_i[SRC_LSB +: 2];
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      moduleOn <= 1'b0;
      frameEnable <= 1'b0;
      commonOrder <= COMMON_ORDER_RESET;
    end else if (ce && wr && !ramHit) begin
      if (adr == ADDR_MODULE_CONTROL) begin
        moduleOn <= wb_dat_i[0];
      end
      if (adr == ADDR_INT_ENABLE) begin
        frameEnable <= wb_dat_i[0]; // [RL2]
      end
      if (adr == ADDR_DISPLAY_CONTROL) begin
        commonOrder <= wb_dat_i[COMMON_ORDER_BIT];
      end
    end
  end
  // ----------------------------------------------------------------
  // display ram: even bytes displayed, odd bytes general purpose
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce && wr && ramHit) begin
      ram[ramIdx[7:0]] <= wb_dat_i[7:0]; // [RL5]
    end
  end
  // ----------------------------------------------------------------
  // operating clock: source select, divider, debug gating
  // ----------------------------------------------------------------
  logic srcPulse;
  logic undivided;
  logic clkRun;
  logic [9:0] divCnt;
  logic [9:0] divLast;
  logic opTick;
  assign srcPulse = srcTick[clockCtl.srcSel];
  assign undivided = clockCtl.srcSel == SRC_LOW_SPEED
                     || clockCtl.srcSel == SRC_EXTERNAL; // [RL8]
  assign clkRun = moduleOn && (!debugMode || clockCtl.debugKeep); // [RL7]
  // divide by 2^(code+4); reserved codes clamp to the largest ratio
  assign divLast = 10'((11'h001 << (DIV_BASE_LOG2 + ((clockCtl.divSel >
                   DIV_MAX_CODE) ? DIV_MAX_CODE : clockCtl.divSel))) - 1);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divCnt <= 10'h000;
    end else if (ce && clkRun && srcPulse) begin
      divCnt <= (divCnt >= divLast) ? 10'h000 : 10'(divCnt + 1); // [RL8]
    end
  end
  assign opTick = clkRun && srcPulse && (undivided || divCnt >= divLast);
  // ----------------------------------------------------------------
  // frame timing: common scan, frame switch event
  // ----------------------------------------------------------------
  logic [15:0] lineCnt;
  logic [1:0] lineSel;
  logic frameSwitch;
  assign frameSwitch = opTick && lineCnt == 16'(FRAME_DIV - 1)
                       && lineSel == 2'(FRAME_LINES - 1);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lineCnt <= 16'h0000;
      lineSel <= 2'h0;
    end else if (ce && opTick) begin
      if (lineCnt == 16'(FRAME_DIV - 1)) begin
        lineCnt <= 16'h0000;
        lineSel <= 2'(lineSel + 1);
      end else begin
        lineCnt <= 16'(lineCnt + 1);
      end
    end
  end
  // ----------------------------------------------------------------
  // frame interrupt flag and request
  // ----------------------------------------------------------------
  logic flagClear;
  assign flagClear = wr && !ramHit && adr == ADDR_INT_FLAG && wb_dat_i[0];
  always_ff @(posedge clk) begin
    if (!rstn) begin
      frameFlag <= 1'b0;
    end else if (ce) begin
      if (frameSwitch) begin
        frameFlag <= 1'b1; // [RL1] [RL10]
      end else if (flagClear) begin
        frameFlag <= 1'b0; // [RL1]
      end
    end
  end
  assign irq = frameFlag && frameEnable; // [RL3]
  // ----------------------------------------------------------------
  // segment and common outputs
  // ----------------------------------------------------------------
  logic [1:0] comIdx;
  assign comIdx = commonOrder ? lineSel : 2'(3 - lineSel); // [RL4]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      commonOut <= '0;
    end else if (ce) begin
      commonOut <= moduleOn ? 4'(4'h1 << lineSel) : 4'h0; // [RL4]
    end
  end
  genvar g;
  generate
    for (g = 0; g < SEGMENTS; g++) begin : gSeg
      always_ff @(posedge clk) begin
        if (!rstn) begin
          segmentOut[g] <= 1'b0;
        end else if (ce) begin
          segmentOut[g] <= moduleOn && ram[2*g][comIdx]; // [RL4]
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // assertions: bus handshake
  // ----------------------------------------------------------------
  ack_answer_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && req |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // ----------------------------------------------------------------
  // assertions: frame flag and request
  // ----------------------------------------------------------------
  flag_set_a: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
    ce && frameSwitch |=> frameFlag)
    else $error("frame switch did not set flag");
  flag_clear_a: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
    ce && flagClear && !frameSwitch |=> !frameFlag)
    else $error("write one did not clear flag");
  flag_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
    !(ce && (frameSwitch || flagClear)) |=> $stable(frameFlag))
    else $error("flag changed with no event");
  flag_read_a: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
    ce && req && !ramHit && adr == ADDR_INT_FLAG
    |=> wb_dat_o[0] == $past(frameFlag))
    else $error("flag read back wrong");
  clear_lose_a: assert property (@(posedge clk) disable iff (!rstn) // [RL10]
    ce && frameSwitch && flagClear |=> frameFlag)
    else $error("clear beat a frame switch");
  zero_keep_a: assert property (@(posedge clk) disable iff (!rstn) // [RL10]
    ce && wr && !ramHit && adr == ADDR_INT_FLAG && !wb_dat_i[0]
    && frameFlag |=> frameFlag)
    else $error("writing zero cleared flag");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rstn) // [RL3]
    irq == (frameFlag && frameEnable))
    else $error("irq not flag and enable");
  irq_rise_a: assert property (@(posedge clk) disable iff (!rstn) // [RL3]
    ce && frameSwitch && frameEnable
    && !(wr && !ramHit && adr == ADDR_INT_ENABLE) |=> irq)
    else $error("frame switch raised no request");
  reset_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // [RL3]
    $rose(rstn) |-> !irq && !frameFlag)
    else $error("request pending after reset");
  enable_wr_a: assert property (@(posedge clk) disable iff (!rstn) // [RL2]
    ce && wr && !ramHit && adr == ADDR_INT_ENABLE
    |=> frameEnable == $past(wb_dat_i[0]))
    else $error("enable write lost");
  enable_read_a: assert property (@(posedge clk) disable iff (!rstn) // [RL2]
    ce && req && !ramHit && adr == ADDR_INT_ENABLE
    |=> wb_dat_o[0] == $past(frameEnable))
    else $error("enable read back wrong");
  // ----------------------------------------------------------------
  // assertions: operating clock
  // ----------------------------------------------------------------
  debug_reset_a: assert property (@(posedge clk) disable iff (!rstn) // [RL6]
    $rose(rstn) |-> clockCtl.debugKeep)
    else $error("debug keep bit reset wrong");
  clk_lock_a: assert property (@(posedge clk) disable iff (!rstn) // [RL9]
    $past(moduleOn) |-> $stable(clockCtl))
    else $error("clock control changed while on");
  debug_stop_a: assert property (@(posedge clk) disable iff (!rstn) // [RL7]
    debugMode && !clockCtl.debugKeep |-> !opTick)
    else $error("clock ran in debug");
  debug_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [RL7]
    ce && debugMode && !clockCtl.debugKeep |=> $stable(lineSel))
    else $error("frame scan moved in debug");
  div_undiv_a: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
    clkRun && srcPulse && undivided |-> opTick)
    else $error("low-speed source was divided");
  div_period_a: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
    clkRun && srcPulse && !undivided && divCnt < divLast |-> !opTick)
    else $error("divided clock ticked early");
  // ----------------------------------------------------------------
  // assertions: display outputs
  // ----------------------------------------------------------------
  com_scan_a: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
    ce && moduleOn |=> $onehot(commonOut))
    else $error("common scan not one-hot");
  com_off_a: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
    ce && !moduleOn |=> commonOut == 4'h0 && segmentOut == '0)
    else $error("outputs driven while off");
endmodule : lcdf_top

//--- tb_top.sv
/*
 tb_top: self-checking bench of lcdf_top over classic wishbone.
 assumes FRAME_DIV 1 and every source tick held high.
*/
`timescale 1ns/1ps
module tb_top;
  import lcdf_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic debugMode = 0;
  logic ce = 1;
  logic [3:0] srcTick = 4'hf;
  logic [31:0] adr = 0;
  logic [31:0] dat = 0;
  logic [31:0] rd;
  logic [31:0] q;
  logic we = 0;
  logic cyc = 0;
  logic stb = 0;
  logic ack;
  logic irq;
  logic [3:0] com;
  logic [3:0] pixFirst;
  logic [3:0] pixSecond;
  logic [87:0] seg;
  int failCount = 0;
  int cmpCount = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  lcdf_top #(.FRAME_DIV(1)) dut_u (.clk(clk), .rstn(rstn), .ce(ce),
    .debugMode(debugMode), .srcTick(srcTick), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(rd), .wb_sel_i(4'hf), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .irq(irq),
    .commonOut(com), .segmentOut(seg));
  lcdf_panel panel_u (.clk(clk), .commonOut(com), .segmentOut(seg),
    .pixFirst(pixFirst), .pixSecond(pixSecond));
  // ------
  // shared tasks
  // ------
  task automatic conclude();
    if (failCount == 0 && cmpCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] g, e);
    cmpCount++;
    if (g !== e) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {20'h0_0000, a};
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  task automatic rdchk(input string n, input logic [11:0] a,
                       input logic [31:0] e);
    wb(0, a, 0);
    chk(n, q, e);
  endtask : rdchk
  // ------
  // scenarios
  // ------
  task automatic t_reset();
    rdchk("clkctl", 12'h000, 32'h0000_0100);
    wb(0, 12'h010, 0);
    chk("comOrder", q[5], 1);
    rdchk("unmapped", 12'h020, 0);
    chk("irq", irq, 0);
  endtask : t_reset
  task automatic t_clkctl();
    wb(1, 12'h000, 32'h0000_0052);
    rdchk("clkctl", 12'h000, 32'h0000_0052);
    wb(1, 12'h004, 1);
    wb(1, 12'h000, 32'h0000_0131);
    rdchk("locked", 12'h000, 32'h0000_0052);
    wb(1, 12'h004, 0);
  endtask : t_clkctl
  task automatic t_frame();
    wb(1, 12'h000, 32'h0000_0101);
    wb(1, 12'h004, 1);
    repeat (20) @(posedge clk);
    rdchk("flag", 12'h008, 1);
    chk("irqMasked", irq, 0);
    wb(1, 12'h00c, 1);
    rdchk("enable", 12'h00c, 1);
    chk("irqOn", irq, 1);
    wb(1, 12'h004, 0);
    wb(1, 12'h008, 0);
    rdchk("flagKept", 12'h008, 1);
    wb(1, 12'h008, 1);
    rdchk("flagClr", 12'h008, 0);
    chk("irqOff", irq, 0);
  endtask : t_frame
  task automatic t_debug();
    wb(1, 12'h000, 32'h0000_0001);
    debugMode <= 1;
    wb(1, 12'h004, 1);
    repeat (40) @(posedge clk);
    rdchk("halted", 12'h008, 0);
    debugMode <= 0;
    repeat (20) @(posedge clk);
    rdchk("resumed", 12'h008, 1);
    wb(1, 12'h004, 0);
    wb(1, 12'h008, 1);
    wb(1, 12'h000, 32'h0000_0101);
    debugMode <= 1;
    wb(1, 12'h004, 1);
    repeat (20) @(posedge clk);
    rdchk("debugRun", 12'h008, 1);
    debugMode <= 0;
    wb(1, 12'h004, 0);
    wb(1, 12'h008, 1);
  endtask : t_debug
  task automatic t_ram();
    wb(1, 12'h800, 32'h0000_0003);
    wb(1, 12'h808, 32'h0000_0001);
    wb(1, 12'h804, 32'h0000_00a5);
    rdchk("gpRam", 12'h804, 32'h0000_00a5);
    wb(1, 12'h004, 1);
    repeat (20) @(posedge clk);
    chk("pixFirst", pixFirst, 4'h3);
    chk("pixSecond", pixSecond, 4'h1);
    wb(1, 12'h010, 0);
    repeat (20) @(posedge clk);
    chk("pixFirstRev", pixFirst, 4'hc);
    chk("pixSecondRev", pixSecond, 4'h8);
  endtask : t_ram
  task automatic t_div();
    logic [3:0] c;
    int n;
    wb(1, 12'h004, 0);
    wb(1, 12'h000, 32'h0000_0110);
    wb(1, 12'h004, 1);
    repeat (2) begin
      c = com;
      while (com === c) @(posedge clk);
    end
    c = com;
    n = 0;
    while (com === c) begin
      @(posedge clk);
      n++;
    end
    chk("lineTicks", n, 32);
    c = com;
    ce <= 0;
    repeat (40) @(posedge clk);
    chk("frozen", com, c);
    ce <= 1;
    wb(1, 12'h004, 0);
  endtask : t_div
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    t_reset();
    t_clkctl();
    t_frame();
    t_debug();
    t_ram();
    t_div();
    conclude();
  end
endmodule : tb_top
